// [rtl/adsc_pkg.sv]
package adsc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] PAGE_BLOCKING = 4'h2;
    localparam logic [3:0] PAGE_NONBLOCKING = 4'h3;
    localparam logic [7:0] IDX_CONFIG = 8'h80;
    localparam logic [7:0] IDX_STATUS = 8'h81;
    localparam logic [7:0] IDX_CHANNEL_SELECT = 8'h82;
    localparam logic [7:0] IDX_DONE_FLAGS = 8'h84;
    localparam logic [7:0] IDX_RESULT_FIRST = 8'h86;
    localparam logic [7:0] IDX_RESULT_LAST = 8'ha4;

    // Config fields
    localparam int CFG_IRQ_ENABLE_BIT = 7;
    localparam int CFG_CONTINUOUS_BIT = 6;
    localparam int CFG_OFFSET_COMP_BIT = 5;
    localparam int CFG_SOFT_RESET_BIT = 4;
    localparam int CFG_DIV_HI = 2;
    localparam int CFG_DIV_LO = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Status reset values
    localparam logic [3:0] COUNT_RESET = 4'hf;
    localparam logic [1:0] STATUS_ZERO_BITS = 2'h0;

    // Channel set
    localparam logic [15:0] CHANNEL_MASK = 16'hdfff;
    localparam logic [3:0] FIRST_POS = 4'h0;
    localparam logic [3:0] LAST_POS = 4'hf;
    localparam logic [3:0] POS_TO_CHANNEL = 4'h1;
    localparam logic [5:0] RESULT_PAD = 6'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] HALF_ZERO = 16'h0000;

    // Converter clock cycles per phase
    localparam logic [4:0] SAMPLE_CYCLES = 5'h09;
    localparam logic [4:0] CONVERT_CYCLES = 5'h12;
    localparam logic [4:0] GAP_CYCLES = 5'h04;
    localparam logic [4:0] PHASE_STEP = 5'h01;

    // Prescaler terminal counts for codes 000..111
    function automatic logic [3:0] adsc_div_last(input logic [2:0] code);
        case (code)
            3'h0: adsc_div_last = 4'h9;
            3'h1: adsc_div_last = 4'h7;
            3'h2: adsc_div_last = 4'h5;
            3'h3: adsc_div_last = 4'h3;
            3'h4: adsc_div_last = 4'h1;
            default: adsc_div_last = 4'h0;
        endcase
    endfunction

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_SEEK,
        SEQ_SAMPLE,
        SEQ_CONVERT,
        SEQ_GAP
    } adsc_state_t;

endpackage

// [rtl/adsc_top.sv]
// Register access over Wishbone was decided locally.
`timescale 1ns/10ps

module adsc_top
    import adsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog converter
    output logic conv_clk_en_o,
    output logic conv_reset_o,
    output logic [3:0] conv_channel_o,
    output logic conv_sample_o,
    output logic conv_convert_o,
    output logic conv_offset_comp_o,
    input wire logic [9:0] conv_data_i,
    input wire logic ref_current_limit_i,
    // Interrupt
    output logic irq_o
);

    logic [7:0] converter_config;
    logic [15:0] channel_select, conversion_done_flags;
    logic [9:0] channel_result [16];
    logic seq_done_flag, reference_current_limit_flag;
    logic [3:0] current_channel_count, hi_latch_channel, div_count, pos;
    logic [7:0] hi_latch;
    logic hi_latch_valid, conv_tick;
    adsc_state_t state;
    logic [4:0] phase_count;

    // Bus decode
    logic [11:0] word_idx;
    logic [7:0] reg_off, result_delta;
    logic [3:0] result_channel, pos_channel;
    logic in_window, bus_req, wr_req, rd_req;
    logic hit_config, hit_status, hit_select, hit_done, hit_result;
    logic select_write, seq_start, soft_reset, block_reset;
    logic [15:0] next_channel_select, active_select, done_clear, done_set;
    logic conv_end, seq_done_event, status_read;
    logic [4:0] next_after, next_first;

    // Lowest position at or above start whose channel is selected
    function automatic logic [4:0] find_pos(input logic [15:0] sel,
                                           input logic [3:0] start);
        logic [3:0] p4;
        find_pos = '0;
        for (int p = 15; p >= 0; p--) begin
            p4 = 4'(p);
            if (p4 >= start && sel[p4 - POS_TO_CHANNEL]) begin
                find_pos = {1'b1, p4};
            end
        end
    endfunction

    assign word_idx = wb_adr_i[13:2];
    assign reg_off = word_idx[7:0];
    assign in_window = (wb_adr_i[31:14] == '0) &&
                       (word_idx[11:8] == PAGE_BLOCKING ||
                        word_idx[11:8] == PAGE_NONBLOCKING);
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_req = bus_req && wb_we_i && in_window;
    assign rd_req = bus_req && !wb_we_i && in_window;
    assign hit_config = (reg_off == IDX_CONFIG);
    assign hit_status = (reg_off == IDX_STATUS);
    assign hit_select = (reg_off == IDX_CHANNEL_SELECT);
    assign hit_done = (reg_off == IDX_DONE_FLAGS);
    assign result_delta = reg_off - IDX_RESULT_FIRST;
    assign result_channel = result_delta[4:1];
    assign hit_result = (reg_off >= IDX_RESULT_FIRST) &&
                        (reg_off <= IDX_RESULT_LAST) && !result_delta[0];

    assign soft_reset = converter_config[CFG_SOFT_RESET_BIT];
    assign block_reset = rst_i || soft_reset;

    assign select_write = wr_req && hit_select && (wb_sel_i[1:0] != '0);
    always_comb begin
        next_channel_select = channel_select;
        if (wb_sel_i[0]) begin
            next_channel_select[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            next_channel_select[15:8] = wb_dat_i[15:8];
        end
    end
    // Only a high-byte write starts; zero selection never starts
    assign seq_start = select_write && wb_sel_i[1] &&
                       ((next_channel_select & CHANNEL_MASK) != '0);
    assign active_select = channel_select & CHANNEL_MASK;

    assign pos_channel = pos - POS_TO_CHANNEL;
    assign conv_end = conv_tick && state == SEQ_CONVERT &&
                      phase_count == CONVERT_CYCLES - PHASE_STEP;
    assign next_after = (pos == LAST_POS) ? 5'h00 :
                        find_pos(active_select, pos + POS_TO_CHANNEL);
    assign next_first = find_pos(active_select, FIRST_POS);
    assign seq_done_event = conv_end && !next_after[4];
    assign status_read = rd_req && hit_status;

    // Configuration register, kept through soft reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_config <= CFG_RESET;
        end else if (wr_req && hit_config && wb_sel_i[0]) begin
            converter_config <= wb_dat_i[7:0];
        end
    end

    // Channel select register
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            channel_select <= '0;
        end else if (select_write) begin
            channel_select <= next_channel_select;
        end
    end

    // Converter clock prescaler
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            div_count <= '0;
            conv_tick <= 1'b0;
        end else if (div_count >= adsc_div_last(
                     converter_config[CFG_DIV_HI:CFG_DIV_LO])) begin
            div_count <= '0;
            conv_tick <= 1'b1;
        end else begin
            div_count <= div_count + 4'h1;
            conv_tick <= 1'b0;
        end
    end

    // Channel sequencer
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            state <= SEQ_IDLE;
            pos <= FIRST_POS;
            phase_count <= '0;
        end else if (select_write) begin
            pos <= FIRST_POS;
            phase_count <= '0;
            state <= seq_start ? SEQ_SEEK : SEQ_IDLE;
        end else if (conv_tick) begin
            case (state)
                SEQ_SEEK: begin
                    // One converter cycle per position passed
                    if (active_select[pos_channel]) begin
                        state <= SEQ_SAMPLE;
                        phase_count <= '0;
                    end else if (pos == LAST_POS) begin
                        state <= SEQ_IDLE;
                    end else begin
                        pos <= pos + POS_TO_CHANNEL;
                    end
                end
                SEQ_SAMPLE: begin
                    if (phase_count == SAMPLE_CYCLES - PHASE_STEP) begin
                        state <= SEQ_CONVERT;
                        phase_count <= '0;
                    end else begin
                        phase_count <= phase_count + PHASE_STEP;
                    end
                end
                SEQ_CONVERT: begin
                    if (phase_count == CONVERT_CYCLES - PHASE_STEP) begin
                        phase_count <= '0;
                        if (next_after[4]) begin
                            state <= SEQ_GAP;
                            pos <= next_after[3:0];
                        end else if (converter_config[CFG_CONTINUOUS_BIT] &&
                                     next_first[4]) begin
                            state <= SEQ_GAP;
                            pos <= next_first[3:0];
                        end else begin
                            state <= SEQ_IDLE;
                        end
                    end else begin
                        phase_count <= phase_count + PHASE_STEP;
                    end
                end
                SEQ_GAP: begin
                    if (phase_count == GAP_CYCLES - PHASE_STEP) begin
                        state <= SEQ_SAMPLE;
                        phase_count <= '0;
                    end else begin
                        phase_count <= phase_count + PHASE_STEP;
                    end
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // Channel in conversion
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            current_channel_count <= COUNT_RESET;
        end else if (conv_tick && (state == SEQ_SEEK ?
                     active_select[pos_channel] : state == SEQ_GAP &&
                     phase_count == GAP_CYCLES - PHASE_STEP)) begin
            current_channel_count <= pos_channel;
        end
    end

    // Result storage
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            for (int i = 0; i < 16; i++) begin
                channel_result[i] <= '0;
            end
        end else if (conv_end) begin
            channel_result[pos_channel] <= conv_data_i;
        end
    end

    // Per-channel done flags; a set beats a clear
    always_comb begin
        done_clear = select_write ? '1 : '0;
        done_set = '0;
        if (rd_req && hit_result && wb_sel_i[1]) begin
            done_clear[result_channel] = 1'b1;
        end
        if (conv_end) begin
            done_set[pos_channel] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            conversion_done_flags <= '0;
        end else begin
            conversion_done_flags <= ((conversion_done_flags & ~done_clear) |
                                      done_set) & CHANNEL_MASK;
        end
    end

    // Status flags
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            seq_done_flag <= 1'b0;
        end else if (seq_done_event) begin
            seq_done_flag <= 1'b1;
        end else if (status_read) begin
            seq_done_flag <= 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        reference_current_limit_flag <= !block_reset &&
                                        ref_current_limit_i;
    end
    always_ff @(posedge clk_i) begin
        irq_o <= !block_reset && seq_done_flag &&
                 converter_config[CFG_IRQ_ENABLE_BIT];
    end

    // High-byte latch for byte reads of results
    always_ff @(posedge clk_i) begin
        if (block_reset) begin
            hi_latch <= '0;
            hi_latch_channel <= '0;
            hi_latch_valid <= 1'b0;
        end else if (rd_req && hit_result) begin
            if (wb_sel_i[1:0] == 2'h1) begin
                hi_latch <= channel_result[result_channel][9:2];
                hi_latch_channel <= result_channel;
                hi_latch_valid <= 1'b1;
            end else if (wb_sel_i[1]) begin
                hi_latch_valid <= 1'b0;
            end
        end
    end

    // Bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= '0;
            if (rd_req) begin
                if (hit_config) begin
                    wb_dat_o[7:0] <= converter_config;
                end else if (hit_status) begin
                    wb_dat_o[7:0] <= {seq_done_flag,
                                      reference_current_limit_flag,
                                      STATUS_ZERO_BITS,
                                      current_channel_count};
                end else if (hit_select) begin
                    wb_dat_o[15:0] <= channel_select;
                end else if (hit_done) begin
                    wb_dat_o[15:0] <= conversion_done_flags;
                end else if (hit_result) begin
                    if (wb_sel_i[1:0] == 2'h2 && hi_latch_valid &&
                        hi_latch_channel == result_channel) begin
                        wb_dat_o[15:0] <= {hi_latch, BYTE_ZERO};
                    end else begin
                        wb_dat_o[15:0] <= {channel_result[result_channel],
                                           RESULT_PAD};
                    end
                end
            end
        end
    end

    // Converter control pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_clk_en_o <= 1'b0;
            conv_reset_o <= 1'b1;
            conv_channel_o <= COUNT_RESET;
            conv_sample_o <= 1'b0;
            conv_convert_o <= 1'b0;
            conv_offset_comp_o <= 1'b0;
        end else begin
            conv_clk_en_o <= conv_tick && !soft_reset;
            conv_reset_o <= soft_reset;
            conv_channel_o <= pos_channel;
            conv_sample_o <= !soft_reset && state == SEQ_SAMPLE;
            conv_convert_o <= !soft_reset && state == SEQ_CONVERT;
            // Offset compensation pin follows config bit 5 on every channel
            conv_offset_comp_o <=
                converter_config[CFG_OFFSET_COMP_BIT];
        end
    end

endmodule // adsc_top

// [verification/adsc_top_sva.sv]
`timescale 1ns/10ps
module adsc_top_sva
    import adsc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Converter
    input wire logic conv_clk_en_o,
    input wire logic conv_reset_o,
    input wire logic [3:0] conv_channel_o,
    input wire logic conv_sample_o,
    input wire logic conv_convert_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic rd_stat;
    logic [3:0] smp_ticks;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_stat = req && !wb_we_i && wb_adr_i[31:11] == 21'h000001
        && wb_adr_i[9:2] == 8'h81;
    // Converter ticks seen while sampling
    always_ff @(posedge clk_i) begin
        if (rst_i || !conv_sample_o) begin
            smp_ticks <= 4'h0;
        end else if (conv_clk_en_o) begin
            smp_ticks <= smp_ticks + 4'h1;
        end
    end
    a_ack_latency: assert property (req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_phase_excl: assert property (
        !(conv_sample_o && conv_convert_o))
        else $error("sample and convert together");
    a_sample_len: assert property (
        $fell(conv_sample_o) && conv_convert_o |-> smp_ticks == 4'h9)
        else $error("sampling not nine ticks");
    a_ch13_skip: assert property (
        conv_sample_o |-> conv_channel_o != 4'hd)
        else $error("channel 13 sampled");
    a_channel_order: assert property (
        $changed(conv_channel_o) && !conv_reset_o |->
        conv_channel_o == 4'hf || $past(conv_channel_o) == 4'hf ||
        conv_channel_o > $past(conv_channel_o))
        else $error("channel order broken");
    a_irq_clear: assert property (
        rd_stat && irq_o && !conv_convert_o |-> ##2 !irq_o)
        else $error("status read left interrupt");
    a_unmapped_zero: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i[9:2] == 8'h83 |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_soft_reset: assert property (
        conv_reset_o |-> !conv_sample_o && !conv_convert_o)
        else $error("converter active in reset");
    c_irq: cover property ($rose(irq_o));
    c_sample: cover property ($fell(conv_sample_o) && conv_convert_o);
    c_status: cover property (rd_stat);
endmodule // adsc_top_sva

bind adsc_top adsc_top_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .conv_clk_en_o, .conv_reset_o,
    .conv_channel_o, .conv_sample_o, .conv_convert_o, .irq_o);

// [verification/adsc_conv_model.sv]
`timescale 1ns/10ps
module adsc_conv_model (
    // Clock
    input wire logic clk_i,
    // From sequencer
    input wire logic [3:0] channel_i,
    input wire logic convert_i,
    input wire logic [9:0] base_i,
    // To sequencer
    output logic [9:0] data_o
);
    // Result depends on channel; junk outside conversion
    always_ff @(posedge clk_i) begin
        data_o <= convert_i ? base_i ^ {6'h00, channel_i} : ~data_o;
    end
endmodule // adsc_conv_model

// [verification/test_adsc_sequence_control.sv]
`timescale 1ns/10ps
module test_adsc_sequence_control
    import adsc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0;
    logic lim = 1'b0;
    logic [9:0] base = 10'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, conv_clk_en_o, conv_reset_o, conv_sample_o;
    logic conv_convert_o, conv_offset_comp_o, irq_o;
    logic [3:0] conv_channel_o;
    logic [9:0] conv_data_i;
    logic [63:0] note;
    logic [63:0] q[$];
    int errors = 0;
    int check_count = 0;
    int seed = 32'ha9c6;

    always #2 clk_i = ~clk_i;

    adsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .conv_clk_en_o(conv_clk_en_o),
        .conv_reset_o(conv_reset_o), .conv_channel_o(conv_channel_o),
        .conv_sample_o(conv_sample_o), .conv_convert_o(conv_convert_o),
        .conv_offset_comp_o(conv_offset_comp_o), .conv_data_i(conv_data_i),
        .ref_current_limit_i(lim), .irq_o(irq_o));
    adsc_conv_model u_model (.clk_i(clk_i), .channel_i(conv_channel_o),
        .convert_i(conv_convert_o), .base_i(base), .data_o(conv_data_i));

    task conclude;
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [11:0] idx,
                      input logic [3:0] sel, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {18'h0, idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        check({31'h0, wb_ack_o}, 32'h1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task rd(input logic [11:0] idx, input logic [3:0] sel,
            input logic [31:0] m, input logic [31:0] e);
        q.push_back({m, e});
        wb(1'b0, idx, sel, 32'h0);
    endtask

    task automatic wait_irq;
        int n = 0;
        @(posedge clk_i);
        while (irq_o !== 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        check({31'h0, irq_o}, 32'h1);
    endtask

    // Read results compared in order of issue
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            note = q.pop_front();
            check(wb_dat_o & note[63:32], note[31:0]);
        end
    end

    initial begin
        #40000;
        errors++;
        conclude();
    end

    initial begin
        base = 10'($random(seed));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h281, 4'h1, 32'hff, 32'h0f);
        rd(12'h284, 4'h3, 32'hffff, 32'h0);
        rd(12'h280, 4'h1, 32'hff, 32'h0);
        rd(12'h283, 4'h3, 32'hffffffff, 32'h0);
        lim <= 1'b1;
        wb(1'b1, 12'h380, 4'h1, 32'h85);
        rd(12'h380, 4'h1, 32'hff, 32'h85);
        wb(1'b1, 12'h282, 4'h3, 32'h8003);
        wait_irq();
        rd(12'h284, 4'h3, 32'hffff, 32'h8003);
        rd(12'h281, 4'h1, 32'hff, 32'hc1);
        rd(12'h381, 4'h1, 32'hff, 32'h41);
        rd(12'h286, 4'h3, 32'hffff, {16'h0, base, 6'h0});
        rd(12'h288, 4'h3, 32'hffff, {16'h0, base ^ 10'h1, 6'h0});
        rd(12'h2a4, 4'h1, 32'hff, {24'h0, ~base[1:0], 6'h0});
        rd(12'h2a4, 4'h2, 32'hff00,
           {16'h0, base[9:2] ^ 8'h03, 8'h0});
        rd(12'h284, 4'h3, 32'hffff, 32'h0);
        // Low byte alone must not start
        wb(1'b1, 12'h282, 4'h1, 32'h0001);
        repeat (200) @(posedge clk_i);
        rd(12'h284, 4'h3, 32'hffff, 32'h0);
        // Continuous run, high byte start, then stop
        wb(1'b1, 12'h280, 4'h1, 32'hc5);
        wb(1'b1, 12'h282, 4'h2, 32'h8000);
        wait_irq();
        rd(12'h281, 4'h1, 32'h80, 32'h80);
        wait_irq();
        rd(12'h284, 4'h3, 32'hffff, 32'h8001);
        wb(1'b1, 12'h282, 4'h3, 32'h0);
        rd(12'h284, 4'h3, 32'hffff, 32'h0);
        rd(12'h281, 4'h1, 32'h80, 32'h80);
        repeat (100) @(posedge clk_i);
        rd(12'h281, 4'h1, 32'h80, 32'h0);
        // Soft reset clears converter state
        wb(1'b1, 12'h280, 4'h1, 32'h85);
        wb(1'b1, 12'h282, 4'h3, 32'h8000);
        wait_irq();
        wb(1'b1, 12'h280, 4'h1, 32'h95);
        rd(12'h284, 4'h3, 32'hffff, 32'h0);
        check({31'h0, conv_reset_o}, 32'h1);
        rd(12'h281, 4'h1, 32'hbf, 32'h0f);
        wb(1'b1, 12'h280, 4'h1, 32'h05);
        wb(1'b1, 12'h282, 4'h3, 32'h8000);
        repeat (100) @(posedge clk_i);
        check({31'h0, irq_o}, 32'h0);
        rd(12'h281, 4'h1, 32'h80, 32'h80);
        // Divide by ten, offset compensation on
        wb(1'b1, 12'h280, 4'h1, 32'h20);
        wb(1'b1, 12'h282, 4'h3, 32'h8000);
        check({31'h0, conv_offset_comp_o}, 32'h1);
        repeat (200) @(posedge clk_i);
        rd(12'h284, 4'h3, 32'hffff, 32'h0);
        repeat (200) @(posedge clk_i);
        rd(12'h284, 4'h3, 32'hffff, 32'h8000);
        conclude();
    end
endmodule // test_adsc_sequence_control
